/* limp_home_checker.sv */
// Port checker for the limp-home register slice, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module limp_home_checker
   import limp_home_pkg::*;
(
   // Watched ports
   input wire logic clk,
   input wire logic sys_rst,
   input wire reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic ref_sample_valid,
   input wire logic [CODE_W-1:0] backup_current_ref_input,
   input wire logic limp_home_mode,
   input wire dac_codes_t dac_codes
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_wr(logic [7:0] a);
      reg_req.wr_en && reg_req.addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      reg_req.rd_en && reg_req.addr == a ##1 reg_rvalid;
   endsequence
   property p_ch1h;
      s_wr(OFF_CH1_CURRENT_HIGH) |=> dac_codes.ch1_backup_current_code[9:2] == $past(reg_req.wdata);
   endproperty
   a_ch1h: assert property (p_ch1h) else $error("ch1 high byte not applied");
   property p_ch1l;
      s_wr(OFF_CH1_CURRENT_LOW) |=> dac_codes.ch1_backup_current_code[1:0] == $past(reg_req.wdata[1:0]);
   endproperty
   a_ch1l: assert property (p_ch1l) else $error("ch1 low bits not applied");
   property p_ch2h;
      s_wr(OFF_CH2_CURRENT_HIGH) |=> dac_codes.ch2_backup_current_code[9:2] == $past(reg_req.wdata);
   endproperty
   a_ch2h: assert property (p_ch2h) else $error("ch2 high byte not applied");
   property p_ch2l;
      s_wr(OFF_CH2_CURRENT_LOW) |=> dac_codes.ch2_backup_current_code[1:0] == $past(reg_req.wdata[1:0]);
   endproperty
   a_ch2l: assert property (p_ch2l) else $error("ch2 low bits not applied");
   property p_flow;
      s_rd(OFF_REF_FILTERED_LOW) |-> reg_rdata[7:2] == 6'h00;
   endproperty
   a_flow: assert property (p_flow) else $error("filtered low reserved bits set");
   property p_rv;
      reg_req.rd_en |=> reg_rvalid ##1 !reg_rvalid || $past(reg_req.rd_en);
   endproperty
   a_rv: assert property (p_rv) else $error("read answer missing");
   property p_hold;
      !reg_req.wr_en |=> $stable(dac_codes[19:0]);
   endproperty
   a_hold: assert property (p_hold) else $error("codes moved without a write");
   property p_mode;
      limp_home_mode |=> dac_codes.backup_active;
   endproperty
   a_mode: assert property (p_mode) else $error("mode not passed on");
endmodule
bind limp_home_current_regs limp_home_checker chk_i(.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ref_sample_valid(ref_sample_valid),
   .backup_current_ref_input(backup_current_ref_input), .limp_home_mode(limp_home_mode), .dac_codes(dac_codes));

/* limp_home_current_regs.sv */
// Limp-home current register slice: reference-input measurement readback
// and the two channels' backup analog current codes.
// Assumes the serial port decoder and the reference ADC run on clk.
// Reads answer one cycle after the strobe; writes act at the strobe's edge.
`timescale 1ns/1ps

// Notes on behaviour
// - Address 0x21 reads sample bits 9..2 of the reference input, read only.
// - Address 0x20 reads sample bits 1..0, upper bits zero, read only.
// - Reference code is 10 bits, one count equals 2.45 V over 1023.
// - Address 0x22 reads filtered bits 1..0, bits 7..2 zero.
// - Address 0x23 reads filtered bits 9..2.
// - Filtered low bits are captured only when 0x23 is read.
// - Address 0x24 holds channel 1 code bits 1..0, reset zero.
// - Address 0x25 holds channel 1 code bits 9..2, reset zero.
// - Address 0x26 holds channel 2 code bits 1..0, reset zero.
// - Address 0x27 holds channel 2 code bits 9..2, reset zero.
// - Each channel's 10-bit code drives its converter in limp-home mode.
module limp_home_current_regs
   import limp_home_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port from the serial decoder
   input wire reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Reference input converter
   input wire logic ref_sample_valid,
   input wire logic [CODE_W-1:0] backup_current_ref_input,
   // Mode and converter codes
   input wire logic limp_home_mode,
   output dac_codes_t dac_codes
);

   // Register map of this slice:
   // 0x20 raw reference bits 1..0, 0x21 raw reference bits 9..2
   // 0x22 filtered bits 1..0 as snapshot, 0x23 filtered bits 9..2
   // 0x24 and 0x25 channel 1 code bits 1..0 and 9..2
   // 0x26 and 0x27 channel 2 code bits 1..0 and 9..2
   // Measurement bytes are read only; the current bytes are read and write.
   // The current bytes reset to zero; reserved bits read zero and drop writes.
   // Unmapped offsets read zero and ignore writes, so a map walk sees clean holes.

   // All slice state in one word: the comb block builds the copy, the flop block keeps it
   typedef struct packed {
      // Channel current bytes
      logic [LOW_W-1:0] ch1_low;
      logic [HIGH_W-1:0] ch1_high;
      logic [LOW_W-1:0] ch2_low;
      logic [HIGH_W-1:0] ch2_high;
      // Reference measurement
      logic [CODE_W-1:0] sample;
      logic [FILT_ACC_W-1:0] filt_acc;
      logic [LOW_W-1:0] filt_low_snap;
      // Read answer and mode
      logic [7:0] rdata;
      logic rvalid;
      logic active;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Live filter output and the byte a read returns this cycle.
   // Both are combinational and only ever reach the outputs through flops.
   logic [CODE_W-1:0] filtered_ref_value;
   logic [7:0] read_byte;

   // Each channel's 10-bit code as the converter sees it
   logic [CODE_W-1:0] ch1_code;
   logic [CODE_W-1:0] ch2_code;

   // Write strobes, one per writable byte
   logic wr_ch1_low;
   logic wr_ch1_high;
   logic wr_ch2_low;
   logic wr_ch2_high;

   // Read strobes, one per mapped address
   logic rd_sample_low;
   logic rd_sample_high;
   logic rd_filt_low;
   logic rd_filt_high;
   logic rd_ch1_low;
   logic rd_ch1_high;
   logic rd_ch2_low;
   logic rd_ch2_high;

   // Exact address match; neighbouring offsets never alias
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // A 2-bit field as a full byte, reserved bits reading zero
   function automatic logic [7:0] pad_low(input logic [LOW_W-1:0] bits);
      pad_low = {{(8 - LOW_W){1'b0}}, bits};
   endfunction

   // The writable low bits of a write; the reserved bits never reach a flop
   function automatic logic [LOW_W-1:0] store_low(input logic [7:0] wdata);
      store_low = wdata[LOW_W-1:0];
   endfunction

   // Upper eight bits of a 10-bit code
   function automatic logic [HIGH_W-1:0] code_high(input logic [CODE_W-1:0] code);
      code_high = code[CODE_W-1:LOW_W];
   endfunction

   // Lower two bits of a 10-bit code
   function automatic logic [LOW_W-1:0] code_low(input logic [CODE_W-1:0] code);
      code_low = code[LOW_W-1:0];
   endfunction

   // Rebuild a 10-bit code from its high byte and low bits
   function automatic logic [CODE_W-1:0] join_code(input logic [HIGH_W-1:0] high,
      input logic [LOW_W-1:0] low);
      join_code = {high, low};
   endfunction

   // Filter output: integer part of the accumulator.
   // The fraction bits stay inside and are never shown to the host.
   function automatic logic [CODE_W-1:0] filter_out(input logic [FILT_ACC_W-1:0] acc);
      filter_out = acc[FILT_ACC_W-1:FILT_SHIFT];
   endfunction

   // One first-order filter step toward the new sample.
   // The accumulator carries FILT_SHIFT fraction bits, so a small step still
   // settles fully instead of stalling one count short.
   // Trade-off: a slow response, each sample closes only a fraction of the gap.
   function automatic logic [FILT_ACC_W-1:0] filter_step(input logic [FILT_ACC_W-1:0] acc,
      input logic [CODE_W-1:0] smp);
      logic [FILT_ACC_W-1:0] gain;
      logic [FILT_ACC_W-1:0] loss;
      gain = {{FILT_SHIFT{1'b0}}, smp};
      loss = {{FILT_SHIFT{1'b0}}, filter_out(acc)};
      filter_step = acc + gain - loss;
   endfunction

   // Address decode, shared by the write and read paths.
   // A read and a write in one cycle are decoded independently.
   assign wr_ch1_low = reg_req.wr_en
      && hit(reg_req.addr, OFF_CH1_CURRENT_LOW);
   assign wr_ch1_high = reg_req.wr_en
      && hit(reg_req.addr, OFF_CH1_CURRENT_HIGH);
   assign wr_ch2_low = reg_req.wr_en
      && hit(reg_req.addr, OFF_CH2_CURRENT_LOW);
   assign wr_ch2_high = reg_req.wr_en
      && hit(reg_req.addr, OFF_CH2_CURRENT_HIGH);

   assign rd_sample_low = reg_req.rd_en
      && hit(reg_req.addr, OFF_REF_SAMPLE_LOW);
   assign rd_sample_high = reg_req.rd_en
      && hit(reg_req.addr, OFF_REF_SAMPLE_HIGH);
   assign rd_filt_low = reg_req.rd_en
      && hit(reg_req.addr, OFF_REF_FILTERED_LOW);
   assign rd_filt_high = reg_req.rd_en
      && hit(reg_req.addr, OFF_REF_FILTERED_HIGH);
   assign rd_ch1_low = reg_req.rd_en
      && hit(reg_req.addr, OFF_CH1_CURRENT_LOW);
   assign rd_ch1_high = reg_req.rd_en
      && hit(reg_req.addr, OFF_CH1_CURRENT_HIGH);
   assign rd_ch2_low = reg_req.rd_en
      && hit(reg_req.addr, OFF_CH2_CURRENT_LOW);
   assign rd_ch2_high = reg_req.rd_en
      && hit(reg_req.addr, OFF_CH2_CURRENT_HIGH);

   assign filtered_ref_value = filter_out(state_reg.filt_acc);
   assign ch1_code = join_code(state_reg.ch1_high, state_reg.ch1_low);
   assign ch2_code = join_code(state_reg.ch2_high, state_reg.ch2_low);

   // Read data mux, from registered state only. Unmapped offsets read zero
   // instead of stale data.
   always_comb begin
      read_byte = UNMAPPED_READ;
      // Raw sample, low bits, read live
      if (rd_sample_low) begin
         read_byte = pad_low(code_low(state_reg.sample));
      end

      // Raw sample, high byte, read live
      if (rd_sample_high) begin
         read_byte = code_high(state_reg.sample);
      end

      // Filtered low bits as frozen by the last high-byte read
      if (rd_filt_low) begin
         read_byte = pad_low(state_reg.filt_low_snap);
      end

      // Filtered high byte, fresh on every read
      if (rd_filt_high) begin
         read_byte = code_high(filtered_ref_value);
      end

      // Channel 1 low bits
      if (rd_ch1_low) begin
         read_byte = pad_low(state_reg.ch1_low);
      end

      // Channel 1 high byte
      if (rd_ch1_high) begin
         read_byte = state_reg.ch1_high;
      end

      // Channel 2 low bits
      if (rd_ch2_low) begin
         read_byte = pad_low(state_reg.ch2_low);
      end

      // Channel 2 high byte
      if (rd_ch2_high) begin
         read_byte = state_reg.ch2_high;
      end
   end

   // Next state: start from the held state, then apply this cycle's events
   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;

      // Mode is only passed on; the converters choose the backup codes with it
      state_next.active = limp_home_mode;

      // Raw sample capture; the converter already delivers the scaled 10-bit code
      if (ref_sample_valid) begin
         state_next.sample = backup_current_ref_input;
         state_next.filt_acc = filter_step(state_reg.filt_acc, backup_current_ref_input);
      end

      // Writes store only the writable bits of the current bytes.
      // Writes to the measurement bytes or unmapped offsets fall away.
      // Each byte acts at once, with no staging until its partner arrives.
      // Channel 1 low bits
      if (wr_ch1_low) begin
         state_next.ch1_low = store_low(reg_req.wdata);
      end

      // Channel 1 high byte
      if (wr_ch1_high) begin
         state_next.ch1_high = reg_req.wdata;
      end

      // Channel 2 low bits
      if (wr_ch2_low) begin
         state_next.ch2_low = store_low(reg_req.wdata);
      end

      // Channel 2 high byte
      if (wr_ch2_high) begin
         state_next.ch2_high = reg_req.wdata;
      end

      // Reads answer one cycle later. A read and a write of one byte in the same
      // cycle return the old value, because the mux looks at registered state.
      if (reg_req.rd_en) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = read_byte;
      end

      // The low bits freeze with the high byte returned now, so a later low-byte
      // read completes the same snapshot even when the filter has moved on.
      if (rd_filt_high) begin
         state_next.filt_low_snap = code_low(filtered_ref_value);
      end
   end

   // Synchronous reset returns every field to its reset constant
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // Current bytes
         state_reg.ch1_low <= CURRENT_LOW_RESET;
         state_reg.ch1_high <= CURRENT_HIGH_RESET;
         state_reg.ch2_low <= CURRENT_LOW_RESET;
         state_reg.ch2_high <= CURRENT_HIGH_RESET;
         // Measurement
         state_reg.sample <= SAMPLE_RESET;
         state_reg.filt_acc <= FILT_ACC_RESET;
         state_reg.filt_low_snap <= CURRENT_LOW_RESET;
         // Read answer and mode
         state_reg.rdata <= READ_DATA_RESET;
         state_reg.rvalid <= 1'b0;
         state_reg.active <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Read answer straight from flops
   assign reg_rdata = state_reg.rdata;
   assign reg_rvalid = state_reg.rvalid;

   // Codes follow the registers directly, so a single byte write shows next cycle.
   // Limitation: while the host rewrites both bytes the converter briefly sees a mixed code.
   assign dac_codes.backup_active = state_reg.active;
   assign dac_codes.ch1_backup_current_code = ch1_code;
   assign dac_codes.ch2_backup_current_code = ch2_code;

endmodule

/* limp_home_current_regs_bench.sv */
// Bench for the limp-home register slice with a host model and a reference model.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
module limp_home_current_regs_bench;
   import limp_home_pkg::*;
   logic clk, sys_rst, ref_sample_valid, limp_home_mode, reg_rvalid;
   logic [9:0] ref_in;
   logic [7:0] reg_rdata, q;
   reg_req_t reg_req;
   dac_codes_t dac_codes;
   int fails, cmp_count, seed, acc, raw, snap, a;
   logic [7:0] m [8];
   limp_home_current_regs dut(.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .ref_sample_valid(ref_sample_valid), .backup_current_ref_input(ref_in),
      .limp_home_mode(limp_home_mode), .dac_codes(dac_codes));
   limp_home_host_model host(.clk(clk), .rdata(reg_rdata), .req(reg_req));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [20:0] g, input logic [20:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      $display("fails %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [7:0] ex(input int a);
      case (a)
         32'h20: ex = 8'(raw & 3);
         32'h21: ex = 8'(raw >> 2);
         32'h22: ex = 8'(snap);
         32'h23: ex = 8'(acc >> 6);
         32'h24, 32'h25, 32'h26, 32'h27: ex = m[a & 7];
         default: ex = 8'h00;
      endcase
   endfunction
   task automatic rd(input int a);
      host.xfer(1'b0, 8'(a), 8'h00, q);
      chk(21'(q), 21'(ex(a)));
      chk(21'(reg_rvalid), 21'h1);
      if (a == 35) snap = (acc >> 4) & 3;
   endtask
   task automatic wr(input int a, input int d);
      host.xfer(1'b1, 8'(a), 8'(d), q);
      if (a >= 36 && a <= 39) m[a & 7] = 8'((a & 1) ? d & 255 : d & 3);
      chk(21'(dac_codes[19:0]), {1'b0, m[5], m[4][1:0], m[7], m[6][1:0]});
   endtask
   task automatic sample();
      @(posedge clk);
      #1 ref_in = 10'($random(seed));
      ref_sample_valid = 1;
      @(posedge clk);
      raw = ref_in;
      acc = (acc + raw - (acc >> 4)) & 16'h3FFF;
      #1 ref_sample_valid = 0;
   endtask
   initial begin
      seed = 93;
      acc = 0;
      raw = 0;
      snap = 0;
      foreach (m[i]) m[i] = 8'h00;
      sys_rst = 1;
      ref_sample_valid = 0;
      limp_home_mode = 0;
      ref_in = 10'h000;
      repeat (2) @(posedge clk);
      #1 sys_rst = 0;
      for (a = 32; a < 41; a++) rd(a);
      for (int i = 0; i < 40; i++) begin
         wr(32 + ($unsigned($random(seed)) % 9), $random(seed));
         sample();
         rd(35);
         if (i % 2) sample();
         rd(34);
         rd(32 + i % 8);
      end
      chk(21'(dac_codes.backup_active), 21'h0);
      limp_home_mode = 1;
      @(posedge clk);
      #1 chk(21'(dac_codes.backup_active), 21'h1);
      stop_test();
   end
   initial begin
      #100000;
      fails++;
      stop_test();
   end
endmodule

/* limp_home_host_model.sv */
// Host side of the register port: one request, then an idle cycle.
// Assumes the caller waits for reset release before the first request.
`timescale 1ns/1ps
module limp_home_host_model
   import limp_home_pkg::*;
(
   // Register port
   input wire logic clk,
   input wire logic [7:0] rdata,
   output reg_req_t req
);
   initial req = '0;
   // The spare cycle keeps each strobe assignment in its own time step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      #1 req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
      @(posedge clk);
      #1 req = '0;
      q = rdata;
   endtask
endmodule

/* limp_home_pkg.sv */
// Constants and carrier types for the limp-home current register slice.
// Assumes an 8-bit register address space driven by the serial port decoder.
package limp_home_pkg;

   // Register offsets
   localparam logic [7:0] OFF_REF_SAMPLE_LOW = 8'h20;
   localparam logic [7:0] OFF_REF_SAMPLE_HIGH = 8'h21;
   localparam logic [7:0] OFF_REF_FILTERED_LOW = 8'h22;
   localparam logic [7:0] OFF_REF_FILTERED_HIGH = 8'h23;
   localparam logic [7:0] OFF_CH1_CURRENT_LOW = 8'h24;
   localparam logic [7:0] OFF_CH1_CURRENT_HIGH = 8'h25;
   localparam logic [7:0] OFF_CH2_CURRENT_LOW = 8'h26;
   localparam logic [7:0] OFF_CH2_CURRENT_HIGH = 8'h27;

   // Field layout of the 10-bit codes split over a low and a high byte
   localparam int CODE_W = 10;
   localparam int LOW_W = 2;
   localparam int HIGH_W = 8;

   // Reset values
   localparam logic [LOW_W-1:0] CURRENT_LOW_RESET = 2'h0;
   localparam logic [HIGH_W-1:0] CURRENT_HIGH_RESET = 8'h00;
   localparam logic [CODE_W-1:0] SAMPLE_RESET = 10'h000;
   localparam logic [7:0] READ_DATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Converter scale: one count is full scale over 1023 codes
   localparam int REF_FULL_SCALE_UV = 2450000;
   localparam int REF_FULL_SCALE_CODES = 1023;
   localparam int REF_LSB_UV = REF_FULL_SCALE_UV / REF_FULL_SCALE_CODES;

   // Low-pass filter: first-order, weight 1/2**FILT_SHIFT per new sample
   localparam int FILT_SHIFT = 4;
   localparam int FILT_ACC_W = CODE_W + FILT_SHIFT;
   localparam logic [FILT_ACC_W-1:0] FILT_ACC_RESET = 14'h0000;

   // Register port request from the serial decoder
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Current codes toward the two current-setting converters
   typedef struct packed {
      logic backup_active;
      logic [CODE_W-1:0] ch1_backup_current_code;
      logic [CODE_W-1:0] ch2_backup_current_code;
   } dac_codes_t;

endpackage
